// file: design/vrt_pkg.sv
// Purpose: Shared constants of the raster timing generator.
// Assumes: Registers sit on a classic Wishbone slave, one 32-bit word each.
// Notes: All display counters are 12 bits wide; the pixel address is 19 bits wide.
package vrt_pkg;
   // ==========================================================
   // Widths
   localparam int VRT_CW = 12;
   localparam int VRT_WINW = 4;
   localparam int VRT_XW = 19;
   localparam int VRT_AW = 8;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] VRT_OFF_CFG = 8'h00;
   localparam logic [7:0] VRT_OFF_HSE = 8'h04;
   localparam logic [7:0] VRT_OFF_HAB = 8'h08;
   localparam logic [7:0] VRT_OFF_HAE = 8'h0c;
   localparam logic [7:0] VRT_OFF_LTC = 8'h10;
   localparam logic [7:0] VRT_OFF_VSE = 8'h14;
   localparam logic [7:0] VRT_OFF_VAB = 8'h18;
   localparam logic [7:0] VRT_OFF_VAE = 8'h1c;
   localparam logic [7:0] VRT_OFF_FTL = 8'h20;
   localparam logic [7:0] VRT_OFF_WIN = 8'h24;
   localparam logic [7:0] VRT_OFF_VST = 8'h28;
   localparam logic [7:0] VRT_OFF_HST = 8'h2c;

   // ==========================================================
   // Fields of display_config_reg
   localparam int VRT_CFG_SSYNC = 0;
   localparam int VRT_CFG_SBLANK = 1;
   localparam int VRT_CFG_INTL_LSB = 2;
   localparam int VRT_CFG_ACC_LSB = 4;
   localparam int VRT_CFG_DSPON = 6;

   // Codes of interlace_setting.
   localparam logic [1:0] VRT_INTL_NONE = 2'h0;
   localparam logic [1:0] VRT_INTL_FULL = 2'h1;
   localparam logic [1:0] VRT_INTL_SYNC = 2'h2;

   // ==========================================================
   // Reset values
   localparam logic [7:0] VRT_CFG_RST = 8'h40;
   localparam logic [11:0] VRT_HSE_RST = 12'h02f;
   localparam logic [11:0] VRT_HAB_RST = 12'h0c5;
   localparam logic [11:0] VRT_HAE_RST = 12'h345;
   localparam logic [11:0] VRT_LTC_RST = 12'h3a9;
   localparam logic [11:0] VRT_VSE_RST = 12'h007;
   localparam logic [11:0] VRT_VAB_RST = 12'h01c;
   localparam logic [11:0] VRT_VAE_RST = 12'h1ac;
   localparam logic [11:0] VRT_FTL_RST = 12'h1ba;
   localparam logic [3:0] VRT_WIN_RST = 4'h0;
endpackage : vrt_pkg

// file: design/vrt_sync.sv
// Purpose: Two-stage synchroniser for pin levels.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module vrt_sync import vrt_pkg::*; #(
   parameter int W = 3,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // ==========================================================
   // Two flops; pins idle high so the reset value avoids a false edge.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : vrt_sync

// file: design/vrt_counter.sv
// Purpose: Display counter with clear, advance and optional wrap limit.
// Assumes: Clear has priority over advance.
// Notes: Without a limit the counter wraps at its natural range.
`timescale 1ns/1ps
module vrt_counter import vrt_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clr,
   input wire logic inc,
   input wire logic lim_en,
   input wire logic [VRT_CW-1:0] limit,
   output logic [VRT_CW-1:0] count_q,
   output logic wrap
);
   logic [VRT_CW-1:0] count_d;
   logic at_lim;

   // ==========================================================
   // End of range is the programmed limit, or all ones when unlimited.
   assign at_lim = lim_en ? (count_q == limit) : (&count_q);
   assign wrap = inc & at_lim & ~clr;
   assign count_d = clr ? '0 : (wrap ? '0 : count_q + VRT_CW'(inc));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end
endmodule : vrt_counter

// file: design/vrt_timing.sv
// Purpose: Raster timing generator with master and slave sync modes.
// Assumes: clk is the pixel input clock; one count per clock edge.
// Notes: Sync pins are active low; blank is active high.
//
// Operation
// - All display counters are twelve bits wide.
// - Accelerated modes multiply horizontal pixels by 2/4/8.
// - Slave bits make sync and blank external inputs.
// - Slave mode spans up to sixteen horizontal windows.
// - Slave, windows and acceleration reach 524,288 pixels.
// - External sync leaves scan line count unlimited.
// - Interlaced frames use two alternating line fields.
// - Noninterlaced fields carry every scan line.
// - Interlaced-sync repeats identical content in both fields.
// - Horizontal blank is sync plus both porches.
// - Vertical blank is sync plus both porch groups.
// - Slave waits for falling sync edges.
// - Pixels shift only during the active period.
`timescale 1ns/1ps
module vrt_timing import vrt_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [VRT_AW-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   input wire logic hsync_n_pin,
   output logic hsync_n_drv,
   output logic hsync_n_oe,
   input wire logic vsync_n_pin,
   output logic vsync_n_drv,
   output logic vsync_n_oe,
   input wire logic blank_pin,
   output logic blank_drv,
   output logic blank_oe,
   output logic pixel_shift,
   output logic [VRT_XW-1:0] pixel_x,
   output logic [VRT_CW:0] line_index,
   output logic field_odd,
   output logic [3:0] pixels_per_clk,
   output logic line_start
);
   // ==========================================================
   // Register file
   logic [7:0] display_config_reg_q;
   logic [VRT_CW-1:0] hsync_end_count_q;
   logic [VRT_CW-1:0] h_active_begin_q;
   logic [VRT_CW-1:0] h_active_end_q;
   logic [VRT_CW-1:0] line_total_count_q;
   logic [VRT_CW-1:0] vsync_end_count_q;
   logic [VRT_CW-1:0] v_active_begin_q;
   logic [VRT_CW-1:0] v_active_end_q;
   logic [VRT_CW-1:0] frame_total_lines_q;
   logic [VRT_WINW-1:0] win_last_q;
   logic [31:0] rd_data;
   logic [31:0] rd_status_v;
   logic [31:0] rd_status_h;
   logic wb_req;
   logic wb_wr;

   // Byte-lane merge of a write into a twelve-bit register.
   function automatic logic [VRT_CW-1:0] vrt_merge12(
      input logic [VRT_CW-1:0] old,
      input logic [31:0] dat,
      input logic [3:0] sel
   );
      logic [VRT_CW-1:0] res;
      res = old;
      if (sel[0]) begin
         res[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         res[11:8] = dat[11:8];
      end
      return res;
   endfunction : vrt_merge12

   // ==========================================================
   // Configuration decode
   logic slave_sync;
   logic slave_blank;
   logic [1:0] interlace_setting;
   logic [1:0] accel_bits;
   logic dsp_on;
   logic intl_any;

   assign slave_sync = display_config_reg_q[VRT_CFG_SSYNC];
   assign slave_blank = display_config_reg_q[VRT_CFG_SBLANK];
   assign interlace_setting = display_config_reg_q[VRT_CFG_INTL_LSB +: 2];
   assign accel_bits = display_config_reg_q[VRT_CFG_ACC_LSB +: 2];
   assign dsp_on = display_config_reg_q[VRT_CFG_DSPON];
   assign intl_any = (interlace_setting == VRT_INTL_FULL) || (interlace_setting == VRT_INTL_SYNC);

   // ==========================================================
   // Wishbone slave: one wait state, ack drops the cycle after it rose.
   assign wb_req = wb_cyc & wb_stb & ~wb_ack;
   assign wb_wr = wb_req & wb_we;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
      end else begin
         wb_ack <= wb_req;
         wb_dat_r <= wb_req ? rd_data : 32'h0000_0000;
      end
   end

   // Register writes; reserved bits are not stored and unmapped writes are dropped.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         display_config_reg_q <= VRT_CFG_RST;
         hsync_end_count_q <= VRT_HSE_RST;
         h_active_begin_q <= VRT_HAB_RST;
         h_active_end_q <= VRT_HAE_RST;
         line_total_count_q <= VRT_LTC_RST;
         vsync_end_count_q <= VRT_VSE_RST;
         v_active_begin_q <= VRT_VAB_RST;
         v_active_end_q <= VRT_VAE_RST;
         frame_total_lines_q <= VRT_FTL_RST;
         win_last_q <= VRT_WIN_RST;
      end else if (wb_wr) begin
         unique case (wb_adr)
            VRT_OFF_CFG: begin
               if (wb_sel[0]) begin
                  display_config_reg_q <= {1'b0, wb_dat_w[6:0]};
               end
            end
            VRT_OFF_HSE: hsync_end_count_q <= vrt_merge12(hsync_end_count_q, wb_dat_w, wb_sel);
            VRT_OFF_HAB: h_active_begin_q <= vrt_merge12(h_active_begin_q, wb_dat_w, wb_sel);
            VRT_OFF_HAE: h_active_end_q <= vrt_merge12(h_active_end_q, wb_dat_w, wb_sel);
            VRT_OFF_LTC: line_total_count_q <= vrt_merge12(line_total_count_q, wb_dat_w, wb_sel);
            VRT_OFF_VSE: vsync_end_count_q <= vrt_merge12(vsync_end_count_q, wb_dat_w, wb_sel);
            VRT_OFF_VAB: v_active_begin_q <= vrt_merge12(v_active_begin_q, wb_dat_w, wb_sel);
            VRT_OFF_VAE: v_active_end_q <= vrt_merge12(v_active_end_q, wb_dat_w, wb_sel);
            VRT_OFF_FTL: frame_total_lines_q <= vrt_merge12(frame_total_lines_q, wb_dat_w, wb_sel);
            VRT_OFF_WIN: begin
               if (wb_sel[0]) begin
                  win_last_q <= wb_dat_w[3:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Pin synchronisers and falling-edge detection.
   logic [2:0] pins_s;
   logic hs_s;
   logic vs_s;
   logic bl_s;
   logic hs_prev_q;
   logic vs_prev_q;
   logic hs_fall;
   logic vs_fall;

   vrt_sync #(.W(3), .INIT(3'h7)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({blank_pin, vsync_n_pin, hsync_n_pin}),
      .q(pins_s)
   );

   assign hs_s = pins_s[0];
   assign vs_s = pins_s[1];
   assign bl_s = pins_s[2];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hs_prev_q <= 1'b1;
         vs_prev_q <= 1'b1;
      end else begin
         hs_prev_q <= hs_s;
         vs_prev_q <= vs_s;
      end
   end

   // Edges count only while sync is an input, so a mode switch cannot fake one.
   assign hs_fall = slave_sync & hs_prev_q & ~hs_s;
   assign vs_fall = slave_sync & vs_prev_q & ~vs_s;

   // ==========================================================
   // Horizontal and vertical counters.
   logic [VRT_CW-1:0] hcount;
   logic [VRT_CW-1:0] vline;
   logic h_wrap;
   logic v_wrap;
   logic v_inc;
   logic [VRT_WINW-1:0] win_q;
   logic field_q;

   // Master wraps at line_total_count; slave restarts on the hsync edge.
   vrt_counter u_hcnt (
      .clk(clk),
      .rstn(rstn),
      .clr(hs_fall),
      .inc(1'b1),
      .lim_en(~slave_sync),
      .limit(line_total_count_q),
      .count_q(hcount),
      .wrap(h_wrap)
   );

   // In slave mode no frame limit applies; the count simply rolls over.
   assign v_inc = slave_sync ? hs_fall : h_wrap;
   vrt_counter u_vcnt (
      .clk(clk),
      .rstn(rstn),
      .clr(vs_fall),
      .inc(v_inc),
      .lim_en(~slave_sync),
      .limit(frame_total_lines_q),
      .count_q(vline),
      .wrap(v_wrap)
   );

   // Window index extends a slave line past one counter range.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         win_q <= '0;
      end else if (!slave_sync || hs_fall) begin
         win_q <= '0;
      end else if (h_wrap && (win_q != win_last_q)) begin
         win_q <= win_q + 4'h1;
      end
   end

   // Field parity flips at each field start in the interlaced modes only.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         field_q <= 1'b0;
      end else if (!intl_any) begin
         field_q <= 1'b0;
      end else if (slave_sync ? vs_fall : v_wrap) begin
         field_q <= ~field_q;
      end
   end

   // ==========================================================
   // Internal timing compares.
   logic h_act_int;
   logic v_act_int;
   logic hsync_int;
   logic vsync_int;
   logic active;
   logic [VRT_CW-1:0] h_rel;
   logic [VRT_XW-1:0] x_next;
   logic [VRT_CW:0] line_next;
   logic [3:0] accel_factor;

   // Blanking covers sync and both porches: everything outside the active span.
   assign h_act_int = (hcount >= h_active_begin_q) && (hcount < h_active_end_q);
   assign v_act_int = (vline >= v_active_begin_q) && (vline < v_active_end_q);
   assign hsync_int = hcount <= hsync_end_count_q;
   assign vsync_int = vline <= vsync_end_count_q;

   // External blank replaces the programmed active window when selected.
   assign active = slave_blank ? ~bl_s : (h_act_int & v_act_int);

   // decode; a factor that does not divide the line is the host's fault.
   assign accel_factor = 4'h1 << accel_bits;
   assign h_rel = slave_blank ? hcount : hcount - h_active_begin_q;
   assign x_next = VRT_XW'({win_q, h_rel}) << accel_bits;

   // Interlaced-sync addresses the same line in both fields.
   assign line_next = (interlace_setting == VRT_INTL_FULL) ? {vline, field_q} :
                      (interlace_setting == VRT_INTL_SYNC) ? {vline, 1'b0} :
                      {1'b0, vline};

   // ==========================================================
   // Pin drivers; enables are high while the pin is an output.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hsync_n_drv <= 1'b1;
         vsync_n_drv <= 1'b1;
         blank_drv <= 1'b1;
         hsync_n_oe <= 1'b0;
         vsync_n_oe <= 1'b0;
         blank_oe <= 1'b0;
      end else begin
         hsync_n_drv <= ~hsync_int;
         vsync_n_drv <= ~vsync_int;
         blank_drv <= ~(h_act_int & v_act_int);
         hsync_n_oe <= ~slave_sync;
         vsync_n_oe <= ~slave_sync;
         blank_oe <= ~slave_blank;
      end
   end

   // ==========================================================
   // Pixel stream outputs, one cycle behind the counters.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pixel_shift <= 1'b0;
         pixel_x <= '0;
         line_index <= '0;
         field_odd <= 1'b0;
         pixels_per_clk <= 4'h1;
         line_start <= 1'b0;
      end else begin
         pixel_shift <= active & dsp_on;
         pixel_x <= (active & dsp_on) ? x_next : '0;
         line_index <= line_next;
         field_odd <= field_q;
         pixels_per_clk <= accel_factor;
         line_start <= slave_sync ? hs_fall : h_wrap;
      end
   end

   // ==========================================================
   // Read mux; unmapped reads answer zero.
   assign rd_status_v = {18'h0_0000, field_q, active, vline};
   assign rd_status_h = {16'h0000, win_q, hcount};

   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (wb_adr)
         VRT_OFF_CFG: rd_data = {24'h00_0000, display_config_reg_q};
         VRT_OFF_HSE: rd_data = {20'h0_0000, hsync_end_count_q};
         VRT_OFF_HAB: rd_data = {20'h0_0000, h_active_begin_q};
         VRT_OFF_HAE: rd_data = {20'h0_0000, h_active_end_q};
         VRT_OFF_LTC: rd_data = {20'h0_0000, line_total_count_q};
         VRT_OFF_VSE: rd_data = {20'h0_0000, vsync_end_count_q};
         VRT_OFF_VAB: rd_data = {20'h0_0000, v_active_begin_q};
         VRT_OFF_VAE: rd_data = {20'h0_0000, v_active_end_q};
         VRT_OFF_FTL: rd_data = {20'h0_0000, frame_total_lines_q};
         VRT_OFF_WIN: rd_data = {28'h000_0000, win_last_q};
         VRT_OFF_VST: rd_data = rd_status_v;
         VRT_OFF_HST: rd_data = rd_status_h;
         default: rd_data = 32'h0000_0000;
      endcase
   end
endmodule : vrt_timing

// file: sim/vrt_properties.sv
// Purpose: Port-level assertions for the raster timing generator.
// Assumes: Host keeps each sync end below its active begin.
// Notes: Attached to every vrt_timing instance by the bind at the foot.
`timescale 1ns/1ps
module vrt_properties import vrt_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_ack,
   input wire logic hsync_n_drv,
   input wire logic hsync_n_oe,
   input wire logic vsync_n_drv,
   input wire logic vsync_n_oe,
   input wire logic blank_drv,
   input wire logic blank_oe,
   input wire logic pixel_shift,
   input wire logic [VRT_XW-1:0] pixel_x,
   input wire logic [3:0] pixels_per_clk,
   input wire logic line_start
);
   // ==========================================================
   // Bus handshake
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_req;
      wb_cyc && wb_stb && !wb_ack;
   endsequence
   sequence s_pulse;
      wb_ack ##1 !wb_ack;
   endsequence
   property p_ack_answer;
      s_req |=> s_pulse;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered once");
   // ==========================================================
   // Raster
   // Pixels leave only inside the active window, never during blanking.
   property p_shift_active;
      pixel_shift && blank_oe |-> !blank_drv;
   endproperty
   a_shift_active: assert property (p_shift_active) else $error("shift in blank");
   property p_x_idle;
      !pixel_shift |-> pixel_x == '0;
   endproperty
   a_x_idle: assert property (p_x_idle) else $error("pixel address while idle");
   property p_rate;
      pixels_per_clk inside {4'h1, 4'h2, 4'h4, 4'h8};
   endproperty
   a_rate: assert property (p_rate) else $error("bad pixel rate");
   // A slip in the acceleration decode shows up as a wrong stride.
   property p_x_step;
      pixel_shift && $past(pixel_shift) && $stable(pixels_per_clk) |->
         pixel_x == $past(pixel_x) + VRT_XW'(pixels_per_clk);
   endproperty
   a_x_step: assert property (p_x_step) else $error("pixel stride wrong");
   property p_hs_blank;
      hsync_n_oe && blank_oe && !hsync_n_drv |-> blank_drv;
   endproperty
   a_hs_blank: assert property (p_hs_blank) else $error("hsync outside blank");
   property p_vs_blank;
      vsync_n_oe && blank_oe && !vsync_n_drv |-> blank_drv;
   endproperty
   a_vs_blank: assert property (p_vs_blank) else $error("vsync outside blank");
   property p_line_sync;
      line_start && hsync_n_oe |-> ##[0:2] !hsync_n_drv;
   endproperty
   a_line_sync: assert property (p_line_sync) else $error("line start without sync");
   property p_start_pulse;
      line_start |=> !line_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("line start too long");
endmodule : vrt_properties

bind vrt_timing vrt_properties i_props (.*);

// file: sim/vrt_ext_sync.sv
// Purpose: External sync counters that feed the slave-mode pins.
// Assumes: The bench lets the device win whenever it drives a pin.
// Notes: Counting restarts at a field start each time it is enabled.
`timescale 1ns/1ps
module vrt_ext_sync #(
   parameter int PLEN = 16,
   parameter int PLINES = 20
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic en,
   output logic hsync_n,
   output logic vsync_n,
   output logic blank
);
   int h_q;
   int v_q;
   // ==========================================================
   // Counters
   // Free-running line and field counts, changed just after each edge.
   always @(posedge clk) begin
      if (!rstn || !en) begin
         h_q <= 0;
         v_q <= 0;
      end else begin
         h_q <= (h_q == PLEN - 1) ? 0 : h_q + 1;
         if (h_q == PLEN - 1) v_q <= (v_q == PLINES - 1) ? 0 : v_q + 1;
      end
   end
   // Falling sync marks each line and field start for the device to lock on.
   assign hsync_n = !(en && h_q < 2);
   assign vsync_n = !(en && v_q == 0);
   // The field is taller than the device's own frame, so no internal limit may apply.
   assign blank = !en || h_q < 4 || h_q >= 12 || v_q < 2 || v_q >= PLINES - 2;
endmodule : vrt_ext_sync

// file: sim/video_raster_timing_tb.sv
// Purpose: Self-checking bench for the raster timing generator.
// Assumes: Sync and blank wires have pull-ups when nobody drives them.
// Notes: Timing is reprogrammed to a 10 by 6 raster to keep frames short.
`timescale 1ns/1ps
module video_raster_timing_tb import vrt_pkg::*;;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [VRT_AW-1:0] wb_adr = '0;
   logic [3:0] wb_sel = '0;
   logic [31:0] wb_dat_w = '0;
   logic [31:0] wb_dat_r;
   logic wb_ack, hsync_n_drv, hsync_n_oe, vsync_n_drv, vsync_n_oe, blank_drv, blank_oe;
   logic pixel_shift, field_odd, line_start, p_hs, p_vs, p_bl;
   logic [VRT_XW-1:0] pixel_x;
   logic [VRT_CW:0] line_index;
   logic [3:0] pixels_per_clk;
   logic ext_en = 1'b0;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed = 32'h6592;
   int nls, nhs, nvs, nsh, nbl, ntog;
   logic [VRT_XW-1:0] mx;
   logic [VRT_CW:0] ml;
   logic [31:0] rv;
   logic [31:0] exp_q[$];
   logic [11:0] rst_tab [10] = '{12'h040, 12'h02f, 12'h0c5, 12'h345, 12'h3a9,
      12'h007, 12'h01c, 12'h1ac, 12'h1ba, 12'h000};
   logic [3:0] prog [9] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'h9, 4'h0, 4'h2, 4'h4, 4'h5};
   logic [12:0] intl_max [4] = '{13'h005, 13'h00b, 13'h00a, 13'h005};
   // Device output wins; otherwise the external counters, else the pull-up.
   wire hsync_n_pin = hsync_n_oe ? hsync_n_drv : (ext_en ? p_hs : 1'b1);
   wire vsync_n_pin = vsync_n_oe ? vsync_n_drv : (ext_en ? p_vs : 1'b1);
   wire blank_pin = blank_oe ? blank_drv : (ext_en ? p_bl : 1'b1);

   vrt_timing i_dut (.*);
   vrt_ext_sync i_ext (.clk(clk), .rstn(rstn), .en(ext_en), .hsync_n(p_hs),
      .vsync_n(p_vs), .blank(p_bl));

   // ==========================================================
   // Clock, timeout and read monitor
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         wrap_up();
      end
   end
   // Read data is judged against the oldest note left by the driver.
   always @(posedge clk) begin
      if (wb_ack === 1'b1 && wb_we === 1'b0) chk(wb_dat_r, exp_q.pop_front());
   end

   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   // One classic cycle, held until the edge that samples ack.
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int k;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat_w <= d;
      wb_sel <= s;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack !== 1'b1 && k < 100);
      chk(wb_ack, 1'b1);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      xfer(1'b1, a, d, s);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0, 4'hf);
   endtask : rd
   // Counts raster events over n clocks, starting at a vsync fall.
   task automatic measure(input int n);
      logic p;
      logic f;
      int k;
      p = 1'b0;
      k = 0;
      while (!(p === 1'b1 && vsync_n_pin === 1'b0) && k < 50000) begin
         p = vsync_n_pin;
         @(negedge clk);
         k++;
      end
      chk(k < 50000, 1'b1);
      {nls, nhs, nvs, nsh, nbl, ntog} = '0;
      mx = '0;
      ml = '0;
      f = field_odd;
      repeat (n) begin
         nls += line_start;
         nhs += !hsync_n_pin;
         nvs += !vsync_n_pin;
         nsh += pixel_shift;
         nbl += !blank_pin;
         ntog += (field_odd !== f);
         f = field_odd;
         if (pixel_x > mx) mx = pixel_x;
         if (line_index > ml) ml = line_index;
         @(negedge clk);
      end
   endtask : measure

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 10; i++) rd(8'(i * 4), {20'h0, rst_tab[i]});
      wr(8'h30, $random(seed), 4'hf);
      rd(8'h30, 32'h0);
      wr(8'h04, 32'h00000f00, 4'h2);
      rd(8'h04, 32'h00000f2f);
      done("registers");
      // Display off first, so a moving active window never jumps the stride.
      wr(8'h00, 32'h0, 4'hf);
      for (int i = 1; i < 9; i++) wr(8'(i * 4), {28'h0, prog[i]}, 4'hf);
      for (int a = 0; a < 4; a++) begin
         wr(8'h00, 32'h40 | (a << 4), 4'hf);
         measure(60);
         chk(32'(pixels_per_clk), 32'h1 << a);
         chk(32'(mx), 32'h3 << a);
         chk(nls, 6);
         chk(nhs, 12);
         chk(nvs, 10);
         chk(nsh, 8);
         chk(nbl, 8);
      end
      done("master");
      for (int m = 0; m < 4; m++) begin
         wr(8'h00, 32'h40 | (m << 2), 4'hf);
         measure(120);
         chk(32'(ml), 32'(intl_max[m]));
         chk(ntog > 0, m inside {1, 2});
      end
      done("interlace");
      wr(8'h00, 32'h0, 4'hf);
      rv = $random(seed);
      wr(8'h24, rv, 4'h1);
      rd(8'h24, {28'h0, rv[3:0]});
      measure(60);
      chk(nsh, 0);
      chk(nhs, 12);
      done("display off");
      @(posedge clk);
      ext_en <= 1'b1;
      wr(8'h00, 32'h43, 4'hf);
      measure(320);
      chk({hsync_n_oe, vsync_n_oe, blank_oe}, 3'h0);
      chk(nls, 20);
      chk(nsh, 128);
      chk(ml > 5, 1'b1);
      done("slave");
      wrap_up();
   end
endmodule : video_raster_timing_tb
